// ### verilog/dpd_config_top.sv
// Configuration logic of the dual-loop clock generator
//
// Operation
// - Four power-down bits, one per channel
// - First format field selects first pair buffers
// - Second format field selects second pair buffers
// - CMOS pairs antiphase except marked code
// - Reference copy off when control is zero
// - First loop ratio integer, 80 to 131
// - First ratio is 80 plus six-bit field
// - Port rate is VCO over V times D; the channels here toggle every V*D cycles, a period of 2*V*D
// - Power-up calibration picks one of 32 bands
// - Second ratio is integer plus numerator/denominator
// - Reference divider zero means divide by one
// - VCO divider 2..6, output divider 1..32
// - Output divider code zero divides by 32
`timescale 1ns/10ps
`default_nettype none
`include "dpd_defines.svh"

module dpd_config_top
    import dpd_pkg::*;
#(
    parameter int CAL_CYCLES = `DPD_CAL_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Channel power-down bits
    input wire logic chan_zero_power_off_i,
    input wire logic chan_one_power_off_i,
    input wire logic chan_two_power_off_i,
    input wire logic chan_three_power_off_i,
    // Reference path
    input wire logic refbuf_power_ctrl_i,
    input wire logic ref_div_sel_i,
    // Output format fields
    input wire logic [2:0] first_fmt_i,
    input wire logic [2:0] second_fmt_i,
    // Loop settings
    input wire logic [5:0] first_loop_feedback_field_i,
    input wire logic [5:0] second_loop_integer_field_i,
    input wire logic [11:0] numerator_value_i,
    input wire logic [11:0] denominator_value_i,
    input wire logic sdm_power_off_i,
    input wire logic bleed_enable_i,
    input wire logic band_recal_trigger_i,
    // Channel dividers
    input wire logic [2:0] vco_div_ch_zero_i,
    input wire logic [2:0] vco_div_ch_one_i,
    input wire logic [2:0] vco_div_ch_two_i,
    input wire logic [2:0] vco_div_ch_three_i,
    input wire logic [4:0] post_div_ch_zero_i,
    input wire logic [4:0] post_div_ch_one_i,
    input wire logic [4:0] post_div_ch_two_i,
    input wire logic [4:0] post_div_ch_three_i,
    // Clock ports
    output logic clock_port_zero_p_o,
    output logic clock_port_zero_n_o,
    output logic [1:0] clock_port_zero_mode_o,
    output logic clock_port_one_p_o,
    output logic clock_port_one_n_o,
    output logic [1:0] clock_port_one_mode_o,
    output logic clock_port_two_p_o,
    output logic clock_port_two_n_o,
    output logic [1:0] clock_port_two_mode_o,
    output logic clock_port_three_p_o,
    output logic clock_port_three_n_o,
    output logic [1:0] clock_port_three_mode_o,
    // Reference outputs
    output logic buffered_reference_pin_o,
    output logic pfd_tick_o,
    // Loop status
    output logic [7:0] first_loop_feedback_ratio_o,
    output logic [7:0] second_loop_integer_ratio_o,
    output logic [7:0] second_loop_inst_ratio_o,
    output logic integer_mode_o,
    output logic bleed_active_o,
    output logic frac_setting_error_o,
    // Calibration status
    output logic cal_busy_o,
    output logic [4:0] first_band_o,
    output logic [4:0] second_band_o
);

    // Format decode: {upper port kind, lower port kind, CMOS in phase}
    function automatic logic [4:0] fmt_decode(input logic [2:0] code);
        logic [4:0] r;
        r = {DRV_LVPECL, DRV_LVPECL, 1'b0};
        unique case (code)
            3'h0: r = {DRV_LVPECL, DRV_LVPECL, 1'b0};
            3'h1: r = {DRV_LVDS, DRV_LVDS, 1'b0};
            3'h2: r = {DRV_CMOS, DRV_LVPECL, 1'b0};
            3'h3: r = {DRV_CMOS, DRV_CMOS, 1'b0};
            3'h4: r = {DRV_CMOS, DRV_LVDS, 1'b0};
            3'h5: r = {DRV_LVPECL, DRV_LVDS, 1'b0};
            3'h6: r = {DRV_LVPECL, DRV_CMOS, 1'b0};
            3'h7: r = {DRV_CMOS, DRV_CMOS, (code == `DPD_FMT_IN_PHASE)};
        endcase
        return r;
    endfunction

    // Band from feedback field: 52 legal ratios spread over 32 bands
    function automatic logic [4:0] band_of(input logic [5:0] field);
        logic [5:0] f;
        logic [11:0] scaled;
        f = (field > `DPD_FB_FIELD_MAX) ? `DPD_FB_FIELD_MAX : field;
        scaled = ({6'h00, f} * {5'h00, `DPD_NUM_BANDS}) / 12'h034;
        return scaled[4:0];
    endfunction

    // Ratio from a six-bit field, offset and capped at the documented maximum
    function automatic logic [7:0] ratio_of(input logic [5:0] field);
        logic [7:0] r;
        r = `DPD_FB_BASE + {2'h0, field};
        return (r > `DPD_FB_MAX) ? `DPD_FB_MAX : r;
    endfunction

    // Decoded settings
    wire [4:0] first_fmt_dec = fmt_decode(first_fmt_i);
    wire [4:0] second_fmt_dec = fmt_decode(second_fmt_i);
    wire [7:0] first_ratio = ratio_of(first_loop_feedback_field_i);
    wire [7:0] second_ratio = ratio_of(second_loop_integer_field_i);
    // Modulator steps only with a legal non-zero fraction
    wire num_legal = (numerator_value_i < denominator_value_i);
    logic [11:0] acc_reg; // Fraction accumulator
    wire frac_on = !sdm_power_off_i && (numerator_value_i != 12'h000) && num_legal;
    wire [12:0] acc_sum = {1'b0, acc_reg} + {1'b0, numerator_value_i};
    wire acc_carry = (acc_sum >= {1'b0, denominator_value_i});
    wire [12:0] acc_wrapped = acc_sum - {1'b0, denominator_value_i};

    logic pfd_phase_reg; // Alternates when the reference is halved
    logic pfd_tick; // Phase detector update this cycle
    dpd_cal_state_t cal_state_reg; // Calibration sequencer
    dpd_cal_state_t cal_state_next;
    logic [15:0] cal_cnt_reg; // Calibration time counter
    wire cal_done = (cal_cnt_reg == 16'(CAL_CYCLES - 1));

    // Divide by one ticks every cycle; divide by two every other cycle
    assign pfd_tick = !ref_div_sel_i || pfd_phase_reg;

    // Reference divider phase
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pfd_phase_reg <= 1'b0;
        end else begin
            pfd_phase_reg <= ref_div_sel_i ? ~pfd_phase_reg : 1'b0;
        end
    end

    // Reference copy and phase detector tick, both registered
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            buffered_reference_pin_o <= 1'b0;
            pfd_tick_o <= 1'b0;
        end else begin
            // Half-rate stand-in for the reference, held low when off
            buffered_reference_pin_o <= refbuf_power_ctrl_i
                                        ? ~buffered_reference_pin_o : 1'b0;
            pfd_tick_o <= pfd_tick;
        end
    end

    // Fraction accumulator: a carry adds one to the ratio for one update
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !frac_on) begin
            acc_reg <= 12'h000;
        end else if (pfd_tick) begin
            acc_reg <= acc_carry ? acc_wrapped[11:0] : acc_sum[11:0];
        end
    end

    // Loop ratios and mode flags
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            first_loop_feedback_ratio_o <= `DPD_FB_BASE;
            second_loop_integer_ratio_o <= `DPD_FB_BASE;
            second_loop_inst_ratio_o <= `DPD_FB_BASE;
            integer_mode_o <= 1'b1;
            bleed_active_o <= 1'b0;
            frac_setting_error_o <= 1'b0;
        end else begin
            first_loop_feedback_ratio_o <= first_ratio;
            second_loop_integer_ratio_o <= second_ratio;
            if (!frac_on) begin
                second_loop_inst_ratio_o <= second_ratio;
            end else if (pfd_tick) begin
                second_loop_inst_ratio_o <= second_ratio + {7'h00, acc_carry};
            end
            // Integer mode needs all three settings, as the host must give them
            integer_mode_o <= sdm_power_off_i && !bleed_enable_i
                              && (numerator_value_i == 12'h000);
            bleed_active_o <= bleed_enable_i;
            frac_setting_error_o <= !sdm_power_off_i && !num_legal;
        end
    end

    // Calibration sequencing: reset acts as power-up; the trigger needs 1 then 0
    always_comb begin
        cal_state_next = cal_state_reg;
        unique case (cal_state_reg)
            ST_IDLE: begin
                if (band_recal_trigger_i) begin
                    cal_state_next = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!band_recal_trigger_i) begin
                    cal_state_next = ST_CAL;
                end
            end
            ST_CAL: begin
                if (cal_done) begin
                    cal_state_next = ST_IDLE;
                end
            end
            default: cal_state_next = ST_IDLE;
        endcase
    end

    // Calibration state and timer
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cal_state_reg <= ST_CAL;
            cal_cnt_reg <= 16'h0000;
        end else begin
            cal_state_reg <= cal_state_next;
            cal_cnt_reg <= (cal_state_reg == ST_CAL && !cal_done)
                           ? cal_cnt_reg + 16'h0001 : 16'h0000;
        end
    end

    // Bands are taken from the fields present when calibration ends
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            first_band_o <= `DPD_BAND_RST;
            second_band_o <= `DPD_BAND_RST;
            cal_busy_o <= 1'b1;
        end else begin
            if (cal_state_reg == ST_CAL && cal_done) begin
                first_band_o <= band_of(first_loop_feedback_field_i);
                second_band_o <= band_of(second_loop_integer_field_i);
            end
            cal_busy_o <= (cal_state_next == ST_CAL);
        end
    end

    // Four channels; first loop feeds ports zero and one
    dpd_out_channel u_ch0 (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .power_off_i(chan_zero_power_off_i),
        .vco_div_i(vco_div_ch_zero_i),
        .post_div_i(post_div_ch_zero_i),
        .drv_mode_i(first_fmt_dec[2:1]),
        .cmos_in_phase_i(first_fmt_dec[0]),
        .clk_p_o(clock_port_zero_p_o),
        .clk_n_o(clock_port_zero_n_o),
        .drv_mode_o(clock_port_zero_mode_o)
    );

    dpd_out_channel u_ch1 (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .power_off_i(chan_one_power_off_i),
        .vco_div_i(vco_div_ch_one_i),
        .post_div_i(post_div_ch_one_i),
        .drv_mode_i(first_fmt_dec[4:3]),
        .cmos_in_phase_i(first_fmt_dec[0]),
        .clk_p_o(clock_port_one_p_o),
        .clk_n_o(clock_port_one_n_o),
        .drv_mode_o(clock_port_one_mode_o)
    );

    dpd_out_channel u_ch2 (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .power_off_i(chan_two_power_off_i),
        .vco_div_i(vco_div_ch_two_i),
        .post_div_i(post_div_ch_two_i),
        .drv_mode_i(second_fmt_dec[2:1]),
        .cmos_in_phase_i(second_fmt_dec[0]),
        .clk_p_o(clock_port_two_p_o),
        .clk_n_o(clock_port_two_n_o),
        .drv_mode_o(clock_port_two_mode_o)
    );

    dpd_out_channel u_ch3 (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .power_off_i(chan_three_power_off_i),
        .vco_div_i(vco_div_ch_three_i),
        .post_div_i(post_div_ch_three_i),
        .drv_mode_i(second_fmt_dec[4:3]),
        .cmos_in_phase_i(second_fmt_dec[0]),
        .clk_p_o(clock_port_three_p_o),
        .clk_n_o(clock_port_three_n_o),
        .drv_mode_o(clock_port_three_mode_o)
    );

endmodule

`default_nettype wire

// ### verilog/dpd_defines.svh
// Constants of the dual-loop clock configuration block
`ifndef DPD_DEFINES_SVH
`define DPD_DEFINES_SVH

// Feedback ratio offset and limits
`define DPD_FB_BASE 8'h50
`define DPD_FB_MAX 8'h83
`define DPD_FB_FIELD_MAX 6'h33
`define DPD_FB_FIELD_W 6
// VCO band calibration
`define DPD_NUM_BANDS 7'h20
`define DPD_CAL_TIME_NS 1000
`define DPD_CLK_PERIOD_NS 10
`define DPD_CAL_CYCLES (`DPD_CAL_TIME_NS / `DPD_CLK_PERIOD_NS)
// Channel divider limits
`define DPD_VCO_DIV_MIN 3'h2
`define DPD_VCO_DIV_MAX 3'h6
`define DPD_POST_DIV_ZERO_RATIO 6'h20
// Fraction width
`define DPD_FRAC_W 12
// Format code whose CMOS pairs toggle in phase
`define DPD_FMT_IN_PHASE 3'h7
// Reset values
`define DPD_BAND_RST 5'h00

`endif

// ### verilog/dpd_pkg.sv
// Types shared by the dual-loop clock configuration block
package dpd_pkg;

    // Output buffer kind of one port
    typedef enum logic [1:0] {
        DRV_LVPECL = 2'h0,
        DRV_LVDS = 2'h1,
        DRV_CMOS = 2'h2,
        DRV_OFF = 2'h3
    } dpd_drv_t;

    // Calibration sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CAL = 3'h2,
        ST_ARMED = 3'h4
    } dpd_cal_state_t;

endpackage

// ### verilog/dpd_out_channel.sv
// One output channel: VCO divider, output divider and output buffer
`timescale 1ns/10ps
`default_nettype none
`include "dpd_defines.svh"

module dpd_out_channel
    import dpd_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Channel settings
    input wire logic power_off_i,
    input wire logic [2:0] vco_div_i,
    input wire logic [4:0] post_div_i,
    input wire logic [1:0] drv_mode_i,
    input wire logic cmos_in_phase_i,
    // Port pins
    output logic clk_p_o,
    output logic clk_n_o,
    output logic [1:0] drv_mode_o
);

    logic [2:0] vco_cnt_reg; // Counts VCO stand-in cycles
    logic [5:0] post_cnt_reg; // Counts VCO divider ticks
    logic [2:0] vco_ratio; // Clamped VCO divider ratio
    logic [5:0] post_ratio; // Output divider ratio
    logic vco_tick; // VCO divider wraps
    logic post_wrap; // Output divider wraps on this tick
    logic phase_next; // Next true-side level
    logic n_next; // Next complement-side level

    // Out-of-range codes are clamped so a bad setting never stalls the divider
    assign vco_ratio = (vco_div_i < `DPD_VCO_DIV_MIN) ? `DPD_VCO_DIV_MIN :
                       (vco_div_i > `DPD_VCO_DIV_MAX) ? `DPD_VCO_DIV_MAX : vco_div_i;
    // All-zero output divider code means the largest ratio
    assign post_ratio = (post_div_i == 5'h00) ? `DPD_POST_DIV_ZERO_RATIO
                                              : {1'b0, post_div_i};
    assign vco_tick = (vco_cnt_reg == vco_ratio - 3'h1);
    assign post_wrap = vco_tick && (post_cnt_reg == post_ratio - 6'h01);
    // Toggle once per V*D cycles: port period is 2*V*D stand-in cycles
    assign phase_next = post_wrap ? ~clk_p_o : clk_p_o;
    // Differential kinds and default CMOS pairs are antiphase
    assign n_next = (drv_mode_i == DRV_CMOS && cmos_in_phase_i) ? phase_next
                                                              : ~phase_next;

    // Divider cascade; a powered-down channel holds every stage quiet
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || power_off_i) begin
            vco_cnt_reg <= 3'h0;
            post_cnt_reg <= 6'h00;
            clk_p_o <= 1'b0;
            clk_n_o <= 1'b0;
        end else begin
            vco_cnt_reg <= vco_tick ? 3'h0 : vco_cnt_reg + 3'h1;
            if (vco_tick) begin
                post_cnt_reg <= post_wrap ? 6'h00 : post_cnt_reg + 6'h01;
            end
            clk_p_o <= phase_next;
            clk_n_o <= n_next;
        end
    end

    // Buffer kind reported on the port, off while powered down
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            drv_mode_o <= DRV_OFF;
        end else begin
            drv_mode_o <= power_off_i ? DRV_OFF : drv_mode_i;
        end
    end

endmodule

`default_nettype wire

// ### test/dpd_config_sva.sv
// Assertion checker for the dual-loop configuration block
`timescale 1ns/10ps
`default_nettype none

module dpd_config_sva
    import dpd_pkg::*;
#(
    parameter int CAL_CYCLES = 4
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Watched settings
    input wire logic chan_zero_power_off_i,
    input wire logic refbuf_power_ctrl_i,
    input wire logic [5:0] first_loop_feedback_field_i,
    input wire logic [11:0] numerator_value_i,
    input wire logic [11:0] denominator_value_i,
    input wire logic sdm_power_off_i,
    input wire logic bleed_enable_i,
    input wire logic band_recal_trigger_i,
    // Watched outputs
    input wire logic clock_port_zero_p_o,
    input wire logic clock_port_zero_n_o,
    input wire logic [1:0] clock_port_zero_mode_o,
    input wire logic buffered_reference_pin_o,
    input wire logic [7:0] first_loop_feedback_ratio_o,
    input wire logic integer_mode_o,
    input wire logic frac_setting_error_o,
    input wire logic cal_busy_o,
    input wire logic [4:0] first_band_o
);
    logic [7:0] busy_cnt; // Busy samples in the current calibration

    // Ratio expected from a feedback field; fields above 51 are capped
    function automatic logic [7:0] fb_ratio(input logic [5:0] f);
        return (f > 6'h33) ? 8'h83 : 8'h50 + {2'h0, f};
    endfunction

    // Band expected from a feedback field, spread over 32 bands
    function automatic logic [4:0] fb_band(input logic [5:0] f);
        logic [10:0] m;
        m = {5'h00, (f > 6'h33) ? 6'h33 : f};
        return 5'(m * 11'h020 / 11'h034);
    endfunction

    // Counts busy length so the window can be checked at the fall
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !cal_busy_o) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= busy_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Recalibration handshake: one then zero while idle
    sequence s_arm;
        !cal_busy_o && band_recal_trigger_i;
    endsequence
    sequence s_go;
        !band_recal_trigger_i;
    endsequence

    a_first_ratio_map: assert property (
        !$past(rst_i) |-> first_loop_feedback_ratio_o == fb_ratio($past(first_loop_feedback_field_i)))
        else $error("first loop ratio differs from field plus offset");
    a_refbuf_off_low: assert property (
        !$past(refbuf_power_ctrl_i) |-> !buffered_reference_pin_o)
        else $error("reference copy active while powered down");
    a_integer_mode_flag: assert property (
        !$past(rst_i) |-> integer_mode_o == ($past(sdm_power_off_i) && !$past(bleed_enable_i)
            && $past(numerator_value_i) == 12'h000))
        else $error("integer mode flag wrong");
    a_frac_error_flag: assert property (
        !$past(rst_i) |-> frac_setting_error_o == (!$past(sdm_power_off_i)
            && $past(numerator_value_i) >= $past(denominator_value_i)))
        else $error("fraction error flag wrong");
    a_chan_off_quiet: assert property (
        $past(chan_zero_power_off_i) |-> !clock_port_zero_p_o && !clock_port_zero_n_o
            && clock_port_zero_mode_o == 2'h3)
        else $error("powered down channel still active");
    a_recal_start: assert property (
        s_arm ##1 s_go |=> cal_busy_o [*3])
        else $error("calibration did not start after trigger");
    a_cal_length: assert property (
        $fell(cal_busy_o) |-> busy_cnt >= CAL_CYCLES - 1 && busy_cnt <= CAL_CYCLES + 2)
        else $error("calibration length wrong");
    a_band_select: assert property (
        $fell(cal_busy_o) |-> first_band_o == fb_band($past(first_loop_feedback_field_i)))
        else $error("band does not follow feedback field");
endmodule

bind dpd_config_top dpd_config_sva #(.CAL_CYCLES(CAL_CYCLES)) dpd_config_sva_inst (.*);

`default_nettype wire

// ### test/dpd_clk_rx_model.sv
// Downstream receiver model: measures period and phase of one port
`timescale 1ns/10ps
`default_nettype none

module dpd_clk_rx_model (
    // Sampling clock
    input wire logic ref_clk_i,
    // Port pins under watch
    input wire logic clk_p_i,
    input wire logic clk_n_i,
    // Measurements
    output logic [15:0] period_o,
    output logic same_phase_o
);
    logic [15:0] cnt_reg; // Cycles since last rising p
    logic p_last_reg; // p one edge ago

    // A receiver only sees edges, so the period runs rise to rise
    always_ff @(posedge ref_clk_i) begin
        p_last_reg <= clk_p_i;
        same_phase_o <= (clk_p_i == clk_n_i);
        if (clk_p_i && !p_last_reg) begin
            period_o <= cnt_reg + 16'h0001;
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// ### test/tb_top.sv
// Testbench of the dual-loop configuration block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // Bench-driven settings
    logic ref_clk_i, rst_i, ref_div_sel_i, sdm_power_off_i, bleed_enable_i;
    logic chan_zero_power_off_i, chan_one_power_off_i, chan_two_power_off_i;
    logic chan_three_power_off_i, refbuf_power_ctrl_i, band_recal_trigger_i;
    logic [2:0] first_fmt_i, second_fmt_i, vco_div_ch_zero_i, vco_div_ch_one_i;
    logic [2:0] vco_div_ch_two_i, vco_div_ch_three_i;
    logic [4:0] post_div_ch_zero_i, post_div_ch_one_i, post_div_ch_two_i, post_div_ch_three_i;
    logic [5:0] first_loop_feedback_field_i, second_loop_integer_field_i;
    logic [11:0] numerator_value_i, denominator_value_i;
    // Design outputs
    logic clock_port_zero_p_o, clock_port_zero_n_o, clock_port_one_p_o, clock_port_one_n_o;
    logic clock_port_two_p_o, clock_port_two_n_o, clock_port_three_p_o, clock_port_three_n_o;
    logic [1:0] clock_port_zero_mode_o, clock_port_one_mode_o;
    logic [1:0] clock_port_two_mode_o, clock_port_three_mode_o;
    logic buffered_reference_pin_o, pfd_tick_o, integer_mode_o, bleed_active_o;
    logic frac_setting_error_o, cal_busy_o;
    logic [7:0] first_loop_feedback_ratio_o, second_loop_integer_ratio_o, second_loop_inst_ratio_o;
    logic [4:0] first_band_o, second_band_o;
    logic [15:0] rx_period; // Measured period of port zero
    logic rx_same; // Port zero pins equal
    int failures = 0;
    int cmp_count = 0;
    // Buffer kinds per format code: lower and upper port of a pair
    logic [1:0] lo_kind [8] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [1:0] hi_kind [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0, 2'h2};
    // Divider settings and the rise-to-rise period they give, then feedback fields and the ratios they give
    logic [2:0] v_tab [5] = '{3'h2, 3'h0, 3'h7, 3'h4, 3'h3};
    logic [4:0] d_tab [5] = '{5'h01, 5'h01, 5'h01, 5'h04, 5'h00};
    logic [15:0] p_tab [5] = '{16'h0004, 16'h0004, 16'h000C, 16'h0020, 16'h00C0};
    logic [15:0] f_tab [4] = '{16'h0000, 16'h0005, 16'h0033, 16'h003F};
    logic [15:0] r_tab [4] = '{16'h0050, 16'h0055, 16'h0083, 16'h0083};

    // Short calibration keeps the run brief
    dpd_config_top #(.CAL_CYCLES(4)) dpd_config_top_inst (.*);
    dpd_clk_rx_model dpd_clk_rx_model_inst (.ref_clk_i(ref_clk_i), .clk_p_i(clock_port_zero_p_o),
        .clk_n_i(clock_port_zero_n_o), .period_o(rx_period), .same_phase_o(rx_same));

    // Clock generator, 10 ns period
    always #5 ref_clk_i = ~ref_clk_i;

    // Compares one value and counts it
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Waits edges, then lets their updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // Waits for calibration to finish, bounded
    task automatic wait_cal();
        for (int i = 0; i < 50 && cal_busy_o !== 1'b0; i++) tick(1);
        chk(16'(cal_busy_o), 16'h0000);
    endtask

    // Prints counts and verdict, ends the run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        failures++;
        final_report();
    end

    // Main sequence
    initial begin
        logic a;
        logic [7:0] r;
        {ref_clk_i, rst_i, ref_div_sel_i, sdm_power_off_i, bleed_enable_i} = 5'h19;
        {chan_zero_power_off_i, chan_one_power_off_i, chan_two_power_off_i} = 3'h0;
        {chan_three_power_off_i, refbuf_power_ctrl_i, band_recal_trigger_i} = 3'h2;
        {first_fmt_i, second_fmt_i} = 6'h1B;
        {vco_div_ch_zero_i, vco_div_ch_one_i, vco_div_ch_two_i, vco_div_ch_three_i} = 12'h492;
        {post_div_ch_zero_i, post_div_ch_one_i, post_div_ch_two_i} = 15'h0421;
        post_div_ch_three_i = 5'h01;
        first_loop_feedback_field_i = 6'h14;
        second_loop_integer_field_i = 6'h0A;
        {numerator_value_i, denominator_value_i} = 24'h000000;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        // Power-up calibration picks the bands of the fields held in reset
        tick(2);
        wait_cal();
        chk(16'(first_band_o), 16'h000C);
        chk(16'(second_band_o), 16'h0006);
        // Feedback ratio at both ends of the field and past the cap
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_i);
            first_loop_feedback_field_i <= 6'(f_tab[i]);
            second_loop_integer_field_i <= 6'(f_tab[i]);
            tick(2);
            chk(16'(first_loop_feedback_ratio_o), r_tab[i]);
            chk(16'(second_loop_integer_ratio_o), r_tab[i]);
        end
        // New ratio takes effect in the bands only after one then zero
        @(posedge ref_clk_i);
        band_recal_trigger_i <= 1'b1;
        @(posedge ref_clk_i);
        band_recal_trigger_i <= 1'b0;
        tick(2);
        chk(16'(cal_busy_o), 16'h0001);
        wait_cal();
        chk(16'(first_band_o), 16'h001F);
        chk(16'(second_band_o), 16'h001F);
        // Every format code on both pairs, opposite orders
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk_i);
            first_fmt_i <= 3'(i);
            second_fmt_i <= 3'(7 - i);
            tick(8);
            chk(16'(clock_port_zero_mode_o), 16'(lo_kind[i]));
            chk(16'(clock_port_one_mode_o), 16'(hi_kind[i]));
            chk(16'(clock_port_two_mode_o), 16'(lo_kind[7 - i]));
            chk(16'(clock_port_three_mode_o), 16'(hi_kind[7 - i]));
            chk(16'(rx_same), 16'(i == 7));
        end
        // Port period follows both dividers, with clamping and code zero
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk_i);
            vco_div_ch_zero_i <= v_tab[i];
            post_div_ch_zero_i <= d_tab[i];
            tick(3 * int'(p_tab[i]) + 8);
            chk(rx_period, p_tab[i]);
        end
        // One channel off, its neighbour keeps running
        @(posedge ref_clk_i);
        chan_zero_power_off_i <= 1'b1;
        refbuf_power_ctrl_i <= 1'b0;
        tick(3);
        chk(16'({clock_port_zero_p_o, clock_port_zero_n_o, clock_port_zero_mode_o}), 16'h0003);
        chk(16'(clock_port_one_mode_o), 16'h0002);
        chk(16'({clock_port_one_p_o ^ clock_port_one_n_o, clock_port_two_p_o ^ clock_port_two_n_o,
            clock_port_three_p_o ^ clock_port_three_n_o}), 16'h0003);
        // Reference copy toggles when on, stays low when off
        tick(3);
        chk(16'(buffered_reference_pin_o), 16'h0000);
        @(posedge ref_clk_i);
        refbuf_power_ctrl_i <= 1'b1;
        tick(3);
        a = buffered_reference_pin_o;
        tick(1);
        chk(16'(buffered_reference_pin_o), 16'(!a));
        // Reference divider: every cycle at zero, alternate at one
        chk(16'(pfd_tick_o), 16'h0001);
        @(posedge ref_clk_i);
        ref_div_sel_i <= 1'b1;
        tick(4);
        a = pfd_tick_o;
        tick(1);
        chk(16'(pfd_tick_o), 16'(!a));
        // Fraction one half alternates the ratio by one
        @(posedge ref_clk_i);
        ref_div_sel_i <= 1'b0;
        {sdm_power_off_i, bleed_enable_i, second_loop_integer_field_i} <= 8'h40;
        {numerator_value_i, denominator_value_i} <= 24'h001002;
        tick(6);
        r = second_loop_inst_ratio_o;
        chk(16'(integer_mode_o), 16'h0000);
        chk(16'(bleed_active_o), 16'h0001);
        tick(1);
        chk(16'(r) + 16'(second_loop_inst_ratio_o), 16'h00A1);
        // Numerator equal to denominator is flagged
        @(posedge ref_clk_i);
        numerator_value_i <= 12'h002;
        tick(2);
        chk(16'(frac_setting_error_o), 16'h0001);
        // Integer mode: zero numerator, modulator off, no bleed
        @(posedge ref_clk_i);
        {sdm_power_off_i, bleed_enable_i, numerator_value_i} <= 14'h2000;
        tick(3);
        chk(16'(integer_mode_o), 16'h0001);
        chk(16'(second_loop_inst_ratio_o), 16'h0050);
        final_report();
    end
endmodule

`default_nettype wire
